//--- logic/jesd_link_cfg.svh
// Register map, field positions, reset values and code points of the JESD link block.
// Assumes an APB word bus: a register index is the byte address divided by four.
`ifndef JESD_LINK_CFG_SVH
`define JESD_LINK_CFG_SVH

`define IDX_CAPTURE_CTRL 10'h030
`define IDX_CAPTURE_FLAGS 10'h031
`define IDX_PATH_DELAY 10'h032
`define IDX_TSTAMP_CTRL 10'h050
`define IDX_SYNC_SELECT 10'h202
`define IDX_LINK_CTRL 10'h060
`define IDX_LINK_STATUS 10'h061

`define BIT_RCVR_ON 7
`define BIT_PROC_ON 6
`define BIT_EDGE_CLR 5
`define BIT_DIRTY_CLR 4
`define BIT_EDGE_SEEN 7
`define BIT_DIRTY 6
`define BIT_TSTAMP_EN 5
`define BIT_SYNC_SEL 6
`define DELAY_MSB 3
`define KM1_MSB 4
`define EXTRA_MSB 6
`define EXTRA_LSB 5

`define RST_RCVR_ON 1'b0
`define RST_PROC_ON 1'b0
`define RST_PATH_DELAY 4'h0
`define RST_KM1 5'h03
`define RST_EXTRA 2'h0
`define RST_TSTAMP_EN 1'b0
`define RST_SYNC_SEL 1'b0

`define FRAME_LAST_OCTET 5'h1f
`define DATA_OCTETS 5'h14
`define Q_FIRST_OCTET 5'h0a
`define ILA_LAST_MF 2'h3
`define TAIL_OCTET 8'h00
`define K28_0 8'h1c
`define K28_3 8'h7c
`define K28_4 8'h9c
`define K28_5 8'hbc

`endif

//--- logic/jesd_link_pkg.sv
// Types shared by the JESD link block.
// Assumes one-hot state codes defined here; other numeric values come from jesd_link_cfg.svh.
package jesd_link_pkg;
    typedef enum logic [3:0] {
        LINK_SYNC = 4'b0001,
        LINK_WAIT = 4'b0010,
        LINK_ILA = 4'b0100,
        LINK_DATA = 4'b1000
    } link_state_t;
endpackage : jesd_link_pkg

//--- logic/enc_8b10b.sv
// Registered 8b10b encoder with running disparity.
// Assumes the only control characters requested are K28.x; output bit 9 is sent first.
`timescale 1ns/1ps
module enc_8b10b (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Octet in
    input wire logic [7:0] dataIn,
    input wire logic kIn,
    // Symbol out
    output logic [9:0] symOut
);
    function automatic logic [5:0] code6(input logic [4:0] v);
        case (v)
            5'h00: code6 = 6'b100111;  5'h01: code6 = 6'b011101;
            5'h02: code6 = 6'b101101;  5'h03: code6 = 6'b110001;
            5'h04: code6 = 6'b110101;  5'h05: code6 = 6'b101001;
            5'h06: code6 = 6'b011001;  5'h07: code6 = 6'b111000;
            5'h08: code6 = 6'b111001;  5'h09: code6 = 6'b100101;
            5'h0a: code6 = 6'b010101;  5'h0b: code6 = 6'b110100;
            5'h0c: code6 = 6'b001101;  5'h0d: code6 = 6'b101100;
            5'h0e: code6 = 6'b011100;  5'h0f: code6 = 6'b010111;
            5'h10: code6 = 6'b011011;  5'h11: code6 = 6'b100011;
            5'h12: code6 = 6'b010011;  5'h13: code6 = 6'b110010;
            5'h14: code6 = 6'b001011;  5'h15: code6 = 6'b101010;
            5'h16: code6 = 6'b011010;  5'h17: code6 = 6'b111010;
            5'h18: code6 = 6'b110011;  5'h19: code6 = 6'b100110;
            5'h1a: code6 = 6'b010110;  5'h1b: code6 = 6'b110110;
            5'h1c: code6 = 6'b001110;  5'h1d: code6 = 6'b101110;
            5'h1e: code6 = 6'b011110;  5'h1f: code6 = 6'b101011;
            default: code6 = 6'b000000;
        endcase
    endfunction : code6

    function automatic logic [3:0] code4(input logic [2:0] v);
        case (v)
            3'h0: code4 = 4'b1011;  3'h1: code4 = 4'b1001;
            3'h2: code4 = 4'b0101;  3'h3: code4 = 4'b1100;
            3'h4: code4 = 4'b1101;  3'h5: code4 = 4'b1010;
            3'h6: code4 = 4'b0110;  3'h7: code4 = 4'b1110;
            default: code4 = 4'b0000;
        endcase
    endfunction : code4

    function automatic logic [2:0] ones(input logic [5:0] v);
        ones = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]) + 3'(v[5]);
    endfunction : ones

    logic rd_reg;
    logic [9:0] symOut_reg;
    logic [5:0] sixRaw;
    logic [5:0] six;
    logic rdMid;
    logic [3:0] fourRaw;
    logic fourInv;
    logic [3:0] four;
    logic rd_next;

    always_comb begin
        sixRaw = kIn ? 6'b001111 : code6(dataIn[4:0]);
        // D.07 is balanced but still alternates with disparity.
        six = (rd_reg && (kIn || ones(sixRaw) != 3'd3 || dataIn[4:0] == 5'h07)) ? ~sixRaw : sixRaw;
        rdMid = rd_reg ^ (ones(six) != 3'd3);
        fourRaw = code4(dataIn[7:5]);
        if (!kIn && dataIn[7:5] == 3'h7 && ((!rdMid && six[1:0] == 2'b11) ||
                (rdMid && six[1:0] == 2'b00))) begin
            fourRaw = 4'b0111;
        end
        // Balanced K28 tails invert opposite to data so the comma stays intact.
        if (kIn && ones({2'b00, fourRaw}) == 3'd2 && dataIn[7:5] != 3'h3) begin
            fourInv = !rdMid;
        end else begin
            fourInv = rdMid && (kIn || ones({2'b00, fourRaw}) != 3'd2 || dataIn[7:5] == 3'h3);
        end
        four = fourInv ? ~fourRaw : fourRaw;
        rd_next = rdMid ^ (ones({2'b00, four}) != 3'd2);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_reg <= 1'b0;
            symOut_reg <= 10'h000;
        end else begin
            rd_reg <= rd_next;
            symOut_reg <= {six, four}; // R1
        end
    end

    assign symOut = symOut_reg;

    chk_symbol_balance: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
        $past(rst_b) |-> (ones(symOut[9:4]) + ones({2'b00, symOut[3:0]}) inside {[4:6]}))
        else $error("encoded symbol outside disparity bounds");
endmodule : enc_8b10b

//--- logic/jesd_link_sync.sv
// Transmit side of a one-lane JESD204B Subclass 1 link with SYSREF capture and APB registers.
// Assumes pins sysrefIn, syncSeIn_b and syncDiffIn_b are asynchronous; samples arrive on sys_clk.
//
// Behaviour
// R1: Every transmitted octet is 8b10b encoded before reaching the lane.
// R2: Decimate-by-32 double rate framing uses one lane: five I, five Q, tail.
// R3: SYSREF is sampled by the device clock and aligns the multiframe boundary.
// R4: The system supplies SYSREF synchronous, a sub-harmonic of the multiframe, fixed phase.
// R5: The receiver requests synchronization with SYNC low and releases it with high.
// R6: A select bit takes SYNC from the single-ended or the differential input.
// R7: Time-stamp enable turns the differential pair into a trigger input.
// R8: With time stamping, the trigger level replaces each sample's least significant bit.
// R9: While synchronization is requested, K28.5 commas are sent continuously.
// R10: The receiver holds its request until four consecutive K symbols arrived.
// R11: After release, K symbols continue to the next or a later multiframe boundary.
// R12: The lane-alignment sequence starts with the first frame after that boundary.
// R13: A four-bit setting delays SYSREF ahead of its capture.
// R14: A captured SYSREF rising edge sets a sticky detect flag.
// R15: Writing the detect-clear bit clears the detect flag.
// R16: Marginal SYSREF capture sets a sticky flag that never clears itself.
// R17: Writing the marginal-clear bit clears the marginal-capture flag.
// R18: Separate bits enable the SYSREF receiver and the SYSREF processing.
// R19: The host sweeps the delay and loads the centre of the clean range.
// R20: NCO phase accumulators are reset during the lane-alignment phase.
// R21: For NCO alignment all receivers release their requests in one multiframe.
// R22: With processing enabled, each captured SYSREF edge restarts frame and multiframe counters.
`timescale 1ns/1ps
`include "jesd_link_cfg.svh"
module jesd_link_sync #(
    parameter int DELAY_TAPS = 16,
    parameter int SAMPLES = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link pins
    input wire logic sysrefIn,
    input wire logic syncSeIn_b,
    input wire logic syncDiffIn_b,
    // Sample stream
    input wire logic [15:0] sampleI,
    input wire logic [15:0] sampleQ,
    input wire logic sampleValid,
    // Lane and DDC control
    output logic [9:0] laneSymbol,
    output logic ncoPhaseReset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic rcvrOn_reg, procOn_reg, tsEn_reg, syncSel_reg;
    logic edgeSeen_reg, dirty_reg;
    logic [3:0] pathDelay_reg;
    logic [4:0] kMinus1_reg;
    logic [1:0] extraBounds_reg;
    logic sysrefMeta_reg, sysrefSync_reg, seMeta_reg, seSync_reg, diffMeta_reg, diffSync_reg;
    logic [DELAY_TAPS-1:0] delayLine_reg;
    logic [1:0] tapHist_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, ncoPhaseReset_reg;
    logic [4:0] octetCnt_reg, frameCnt_reg;
    logic [1:0] mfCnt_reg, boundCnt_reg;
    jesd_link_pkg::link_state_t state_reg, state_next;
    logic [15:0] iBuf_reg [SAMPLES];
    logic [15:0] qBuf_reg [SAMPLES];
    logic [2:0] wrIdx_reg;

    // Asynchronous pins pass two flip-flops; the request idles released.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sysrefMeta_reg <= 1'b0;
            sysrefSync_reg <= 1'b0;
            seMeta_reg <= 1'b1;
            seSync_reg <= 1'b1;
            diffMeta_reg <= 1'b1;
            diffSync_reg <= 1'b1;
        end else begin
            sysrefMeta_reg <= sysrefIn; // R3
            // Gating after the first stage keeps logic off the raw asynchronous pin.
            sysrefSync_reg <= sysrefMeta_reg & rcvrOn_reg; // R18
            seMeta_reg <= syncSeIn_b;
            seSync_reg <= seMeta_reg;
            diffMeta_reg <= syncDiffIn_b;
            diffSync_reg <= diffMeta_reg;
        end
    end

    // The pair serves as a trigger while time stamping, so SYNC falls back to single-ended.
    wire useDiff = syncSel_reg & !tsEn_reg; // R6 R7
    wire syncReq = useDiff ? !diffSync_reg : !seSync_reg; // R5
    wire trigLevel = diffSync_reg; // R7

    // SYSREF delay line and capture checks.
    wire sysrefTap = delayLine_reg[pathDelay_reg]; // R13
    wire sysrefEdge = sysrefTap & !tapHist_reg[0]; // R14
    // A level that flips for a single cycle means the capture fell inside setup or hold.
    wire sysrefDirty = (tapHist_reg[1] == sysrefTap) && (tapHist_reg[0] != sysrefTap); // R16
    wire restart = sysrefEdge & procOn_reg; // R22

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            delayLine_reg <= '0;
            tapHist_reg <= 2'b00;
        end else begin
            delayLine_reg <= {delayLine_reg[DELAY_TAPS-2:0], sysrefSync_reg}; // R13
            tapHist_reg <= {tapHist_reg[0], sysrefTap};
        end
    end

    // APB decode.
    wire [9:0] regIdx = paddr[11:2];
    wire apbSetup = psel & !penable;
    wire apbWrite = psel & penable & pwrite;
    wire hitCtrl = regIdx == `IDX_CAPTURE_CTRL;
    wire hitFlags = regIdx == `IDX_CAPTURE_FLAGS;
    wire hitDelay = regIdx == `IDX_PATH_DELAY;
    wire hitTs = regIdx == `IDX_TSTAMP_CTRL;
    wire hitSel = regIdx == `IDX_SYNC_SELECT;
    wire hitLink = regIdx == `IDX_LINK_CTRL;
    wire hitStat = regIdx == `IDX_LINK_STATUS;
    wire mapped = hitCtrl | hitFlags | hitDelay | hitTs | hitSel | hitLink | hitStat;
    wire wrCtrl = apbWrite & hitCtrl;
    wire edgeClr = wrCtrl & pwdata[`BIT_EDGE_CLR];
    wire dirtyClr = wrCtrl & pwdata[`BIT_DIRTY_CLR];
    wire edgeSeen_next = sysrefEdge | (edgeSeen_reg & !edgeClr); // R14 R15
    wire dirty_next = sysrefDirty | (dirty_reg & !dirtyClr); // R16 R17
    wire [7:0] readByte =
        hitCtrl ? {rcvrOn_reg, procOn_reg, 6'h00} :
        hitFlags ? {edgeSeen_reg, dirty_reg, 6'h00} :
        hitDelay ? {4'h0, pathDelay_reg} :
        hitTs ? {2'b00, tsEn_reg, 5'h00} :
        hitSel ? {1'b0, syncSel_reg, 6'h00} :
        hitLink ? {1'b0, extraBounds_reg, kMinus1_reg} :
        hitStat ? {3'b000, syncReq, state_reg} : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rcvrOn_reg <= `RST_RCVR_ON;
            procOn_reg <= `RST_PROC_ON;
            pathDelay_reg <= `RST_PATH_DELAY;
            tsEn_reg <= `RST_TSTAMP_EN;
            syncSel_reg <= `RST_SYNC_SEL;
            kMinus1_reg <= `RST_KM1;
            extraBounds_reg <= `RST_EXTRA;
            edgeSeen_reg <= 1'b0;
            dirty_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            if (wrCtrl) begin
                rcvrOn_reg <= pwdata[`BIT_RCVR_ON]; // R18
                procOn_reg <= pwdata[`BIT_PROC_ON]; // R18
            end
            if (apbWrite & hitDelay) begin
                pathDelay_reg <= pwdata[`DELAY_MSB:0]; // R13
            end
            if (apbWrite & hitTs) begin
                tsEn_reg <= pwdata[`BIT_TSTAMP_EN]; // R7
            end
            if (apbWrite & hitSel) begin
                syncSel_reg <= pwdata[`BIT_SYNC_SEL]; // R6
            end
            if (apbWrite & hitLink) begin
                kMinus1_reg <= pwdata[`KM1_MSB:0];
                extraBounds_reg <= pwdata[`EXTRA_MSB:`EXTRA_LSB];
            end
            edgeSeen_reg <= edgeSeen_next;
            dirty_reg <= dirty_next;
            prdata_reg <= apbSetup ? {24'h00_0000, readByte} : 32'h0000_0000;
            pready_reg <= 1'b1;
            pslverr_reg <= apbSetup & !mapped;
        end
    end

    // Frame and multiframe timing.
    wire lastOctet = octetCnt_reg == `FRAME_LAST_OCTET;
    wire lastOfMf = lastOctet && (frameCnt_reg == kMinus1_reg);
    wire mfStart = (octetCnt_reg == 5'h00) && (frameCnt_reg == 5'h00);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            jesd_link_pkg::LINK_SYNC: begin
                if (!syncReq) state_next = jesd_link_pkg::LINK_WAIT;
            end
            jesd_link_pkg::LINK_WAIT: begin
                if (lastOfMf && boundCnt_reg == extraBounds_reg) begin
                    state_next = jesd_link_pkg::LINK_ILA; // R11 R12
                end
            end
            jesd_link_pkg::LINK_ILA: begin
                if (lastOfMf && mfCnt_reg == `ILA_LAST_MF) state_next = jesd_link_pkg::LINK_DATA;
            end
            jesd_link_pkg::LINK_DATA: begin
                state_next = jesd_link_pkg::LINK_DATA;
            end
            default: begin
                state_next = jesd_link_pkg::LINK_SYNC;
            end
        endcase
        if (syncReq) state_next = jesd_link_pkg::LINK_SYNC; // R9
    end

    wire inWait = state_reg == jesd_link_pkg::LINK_WAIT;
    wire inIla = state_reg == jesd_link_pkg::LINK_ILA;
    wire sendComma = (state_reg == jesd_link_pkg::LINK_SYNC) | inWait;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= jesd_link_pkg::LINK_SYNC;
            octetCnt_reg <= 5'h00;
            frameCnt_reg <= 5'h00;
            mfCnt_reg <= 2'h0;
            boundCnt_reg <= 2'h0;
            ncoPhaseReset_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            octetCnt_reg <= restart ? 5'h00 : 5'(octetCnt_reg + 5'h01); // R22
            if (restart || lastOfMf) begin
                frameCnt_reg <= 5'h00; // R3 R22
            end else if (lastOctet) begin
                frameCnt_reg <= 5'(frameCnt_reg + 5'h01);
            end
            boundCnt_reg <= !inWait ? 2'h0 : lastOfMf ? 2'(boundCnt_reg + 2'h1) : boundCnt_reg;
            mfCnt_reg <= !inIla ? 2'h0 : lastOfMf ? 2'(mfCnt_reg + 2'h1) : mfCnt_reg;
            ncoPhaseReset_reg <= (state_next == jesd_link_pkg::LINK_ILA) && !inIla; // R20
        end
    end

    // Sample store; time stamping swaps the sample LSB for the trigger at capture time.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrIdx_reg <= 3'h0;
            for (int n = 0; n < SAMPLES; n++) begin
                iBuf_reg[n] <= 16'h0000;
                qBuf_reg[n] <= 16'h0000;
            end
        end else if (sampleValid) begin
            iBuf_reg[wrIdx_reg] <= tsEn_reg ? {sampleI[15:1], trigLevel} : sampleI; // R8
            qBuf_reg[wrIdx_reg] <= tsEn_reg ? {sampleQ[15:1], trigLevel} : sampleQ; // R8
            wrIdx_reg <= (wrIdx_reg == 3'(SAMPLES - 1)) ? 3'h0 : 3'(wrIdx_reg + 3'h1);
        end
    end

    // One lane: octets 0-9 carry I0..I4, 10-19 Q0..Q4, the rest are tail.
    wire isQ = octetCnt_reg >= `Q_FIRST_OCTET;
    wire [4:0] qOff = 5'(octetCnt_reg - `Q_FIRST_OCTET);
    wire [2:0] wordSel = isQ ? qOff[3:1] : octetCnt_reg[3:1];
    wire [15:0] selWord = isQ ? qBuf_reg[wordSel] : iBuf_reg[wordSel];
    wire [7:0] selByte = octetCnt_reg[0] ? selWord[7:0] : selWord[15:8];
    wire [7:0] dataOctet = (octetCnt_reg < `DATA_OCTETS) ? selByte : `TAIL_OCTET; // R2
    wire qMarker = (mfCnt_reg == 2'h1) && (frameCnt_reg == 5'h00) && (octetCnt_reg == 5'h01);
    wire ilaK = mfStart | lastOfMf | qMarker;
    wire [7:0] ilaOctet = mfStart ? `K28_0 : lastOfMf ? `K28_3 :
        qMarker ? `K28_4 : {3'b000, octetCnt_reg};
    wire [7:0] encData = sendComma ? `K28_5 : inIla ? ilaOctet : dataOctet; // R9 R11 R12
    wire encK = sendComma | (inIla & ilaK);

    enc_8b10b encoder (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .dataIn(encData),
        .kIn(encK),
        .symOut(laneSymbol)
    ); // R1

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ncoPhaseReset = ncoPhaseReset_reg;

    chk_sync_comma: assert property ( // R9
        (state_reg == jesd_link_pkg::LINK_SYNC) |=>
            (laneSymbol == 10'b0011111010 || laneSymbol == 10'b1100000101))
        else $error("comma not sent while synchronization requested");
    chk_request_resync: assert property (syncReq |=> state_reg == jesd_link_pkg::LINK_SYNC) // R9
        else $error("request did not return the link to comma state");
    chk_wait_hold: assert property (inWait && !syncReq && !lastOfMf |=> inWait) // R11
        else $error("left comma wait away from a multiframe boundary");
    chk_ila_boundary: assert property ($rose(inIla) |-> mfStart) // R12
        else $error("alignment sequence did not start on a multiframe boundary");
    chk_nco_reset: assert property ($rose(inIla) |-> ncoPhaseReset ##1 !ncoPhaseReset) // R20
        else $error("phase reset pulse missing at alignment start");
    chk_edge_sticky: assert property ( // R14
        sysrefEdge |=> edgeSeen_reg ##1 (edgeSeen_reg || $past(edgeClr)))
        else $error("detect flag not held after edge");
    chk_edge_clear: assert property (edgeClr && !sysrefEdge |=> !edgeSeen_reg) // R15
        else $error("detect flag survived its clear");
    chk_dirty_keep: assert property (dirty_reg && !dirtyClr |=> dirty_reg) // R16
        else $error("marginal flag cleared itself");
    chk_dirty_clear: assert property (dirtyClr && !sysrefDirty |=> !dirty_reg) // R17
        else $error("marginal flag survived its clear");
    chk_lmfc_restart: assert property (restart |=> mfStart) // R22
        else $error("counters not restarted by SYSREF edge");
    chk_rcvr_off: assert property (!rcvrOn_reg [*3] |-> !sysrefSync_reg) // R18
        else $error("SYSREF passed a disabled receiver");

    cov_data_reached: cover property ($rose(state_reg == jesd_link_pkg::LINK_DATA));
    cov_edge_restart: cover property (restart);
    cov_dirty_seen: cover property ($rose(dirty_reg));
endmodule : jesd_link_sync

//--- sim/jesd_rx_model.sv
// Behavioural one-lane JESD204B receiver facing the link block.
// Assumes bit 9 of each symbol is first and the bench raises start to begin a link.
`timescale 1ns/1ps
module jesd_rx_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control and lane
    input wire logic start,
    input wire logic [9:0] laneSymbol,
    output logic syncOut_b
);
    logic [2:0] kCount;
    logic isComma;
    assign isComma = (laneSymbol === 10'h0fa) || (laneSymbol === 10'h305);
    // The request drops only once four commas in a row were seen.
    assign syncOut_b = !(start && kCount != 3'h4);
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !start) begin
            kCount <= 3'h0;
        end else if (kCount != 3'h4) begin
            kCount <= isComma ? kCount + 3'h1 : 3'h0;
        end
    end
endmodule : jesd_rx_model

//--- sim/jesd_link_sync_bench.sv
// Self-checking bench for the link block: APB registers, SYSREF capture, link start.
// Assumes the register header of the design and the receiver model beside it.
`timescale 1ns/1ps
`include "jesd_link_cfg.svh"
module jesd_link_sync_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sysrefIn = 1'b0;
    logic syncSeIn_b;
    logic syncDiffIn_b = 1'b1;
    logic [9:0] laneSymbol;
    logic ncoPhaseReset;
    logic rxStart = 1'b0;
    logic [31:0] rdData;
    logic rdErr;
    logic isComma;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [11:0] CTRL = {`IDX_CAPTURE_CTRL, 2'b00};
    localparam logic [11:0] FLAGS = {`IDX_CAPTURE_FLAGS, 2'b00};
    localparam logic [11:0] DELAY = {`IDX_PATH_DELAY, 2'b00};
    localparam logic [11:0] STATUS = {`IDX_LINK_STATUS, 2'b00};
    localparam logic [11:0] LINKC = {`IDX_LINK_CTRL, 2'b00};
    localparam logic [11:0] SELECT = {`IDX_SYNC_SELECT, 2'b00};
    localparam logic [11:0] TSTAMP = {`IDX_TSTAMP_CTRL, 2'b00};
    assign isComma = (laneSymbol === 10'h0fa) || (laneSymbol === 10'h305);
    always #5 sys_clk = ~sys_clk;
    jesd_link_sync jesd_link_sync_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysrefIn(sysrefIn), .syncSeIn_b(syncSeIn_b),
        .syncDiffIn_b(syncDiffIn_b), .sampleI(16'h0000), .sampleQ(16'h0000), .sampleValid(1'b0),
        .laneSymbol(laneSymbol), .ncoPhaseReset(ncoPhaseReset)
    );
    jesd_rx_model jesd_rx_model_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .start(rxStart), .laneSymbol(laneSymbol),
        .syncOut_b(syncSeIn_b)
    );
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Entered just after a rising edge; returns just after one.
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task pulse(input int n);
        sysrefIn <= 1'b1;
        repeat (n) @(posedge sys_clk);
        sysrefIn <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse
    task test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task reg_scenario;
        apb(1'b0, CTRL, 32'h0);
        check("control reset", 32'h0, rdData);
        apb(1'b0, DELAY, 32'h0);
        check("delay reset", 32'h0, rdData);
        apb(1'b1, DELAY, 32'h0000_000f);
        apb(1'b0, DELAY, 32'h0);
        check("delay field", 32'h0000_000f, rdData);
        apb(1'b0, 12'h004, 32'h0);
        check("unmapped error", 32'h1, {31'h0, rdErr});
    endtask : reg_scenario
    task sysref_scenario;
        apb(1'b1, CTRL, 32'h0000_00f0);
        pulse(6);
        repeat (8) @(posedge sys_clk);
        apb(1'b0, FLAGS, 32'h0);
        check("edge held by delay", 32'h0, {31'h0, rdData[7]});
        repeat (10) @(posedge sys_clk);
        apb(1'b0, FLAGS, 32'h0);
        check("edge seen", 32'h1, {31'h0, rdData[7]});
        repeat (20) @(posedge sys_clk);
        apb(1'b0, FLAGS, 32'h0);
        check("edge sticky", 32'h1, {31'h0, rdData[7]});
        apb(1'b1, CTRL, 32'h0000_00e0);
        apb(1'b0, FLAGS, 32'h0);
        check("edge cleared", 32'h0, {31'h0, rdData[7]});
        apb(1'b1, DELAY, 32'h0);
        pulse(1);
        repeat (30) @(posedge sys_clk);
        apb(1'b0, FLAGS, 32'h0);
        check("marginal sticky", 32'h1, {31'h0, rdData[6]});
        apb(1'b1, CTRL, 32'h0000_00d0);
        apb(1'b0, FLAGS, 32'h0);
        check("marginal cleared", 32'h0, {31'h0, rdData[6]});
        apb(1'b1, CTRL, 32'h0000_0030);
        pulse(6);
        repeat (12) @(posedge sys_clk);
        apb(1'b0, FLAGS, 32'h0);
        check("receiver off", 32'h0, {30'h0, rdData[7:6]});
    endtask : sysref_scenario
    task sweep_scenario;
        int d;
        for (d = 0; d < 16; d++) begin
            apb(1'b1, CTRL, 32'h0000_00f0);
            apb(1'b1, DELAY, d);
            pulse(6);
            repeat (22) @(posedge sys_clk);
            apb(1'b0, FLAGS, 32'h0);
            check("clean capture", 32'h2, {30'h0, rdData[7:6]});
        end
        apb(1'b1, DELAY, 32'h0000_0007);
        apb(1'b0, DELAY, 32'h0);
        check("centre delay", 32'h7, rdData);
    endtask : sweep_scenario
    task link_scenario;
        int waitN;
        int bad;
        int late;
        bad = 0;
        late = 0;
        // One extra boundary, four frames per multiframe.
        apb(1'b1, LINKC, 32'h0000_0023);
        rxStart <= 1'b1;
        for (waitN = 0; waitN < 20 && !isComma; waitN++) @(posedge sys_clk);
        check("comma response", 32'h1, {31'h0, isComma});
        for (waitN = 0; waitN < 600 && ncoPhaseReset !== 1'b1; waitN++) begin
            if (!isComma) bad++;
            if (syncSeIn_b === 1'b1) late++;
            @(posedge sys_clk);
        end
        check("commas before alignment", 32'h0, bad);
        check("extra boundary wait", 32'h1, {31'h0, late > 128 && late < 270});
        check("phase reset", 32'h1, {31'h0, ncoPhaseReset});
        check("request released", 32'h1, {31'h0, syncSeIn_b});
        apb(1'b0, STATUS, 32'h0);
        check("alignment state", 32'h4, {28'h0, rdData[3:0]});
    endtask : link_scenario
    task sel_scenario;
        syncDiffIn_b <= 1'b0;
        apb(1'b1, SELECT, 32'h0000_0040);
        apb(1'b0, STATUS, 32'h0);
        check("differential request", 32'h1, {31'h0, rdData[4]});
        apb(1'b1, TSTAMP, 32'h0000_0020);
        apb(1'b0, STATUS, 32'h0);
        check("pair as trigger", 32'h0, {31'h0, rdData[4]});
    endtask : sel_scenario
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        reg_scenario();
        sysref_scenario();
        sweep_scenario();
        link_scenario();
        sel_scenario();
        test_done();
    end
endmodule : jesd_link_sync_bench
